// ==== rtl/rtc_consts.svh ====
// Offsets, field positions, reset values and timing counts of the alarm and clock-out block
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define ALARM0_BASE 8'h00
`define ALARM1_BASE 8'h08
`define ALARM_FIELDS 6
`define ALARM_MATCH_BIT 7
`define PROTECT_OFS 8'h10
`define IRQCTL_OFS 8'h11
`define TRIM_OFS 8'h12
`define STATUS_OFS 8'h3F

`define PROTECT_SEL_MSB 7
`define PROTECT_SEL_LSB 5
`define REPEAT_BIT 7
`define AL1_ON_BIT 6
`define AL0_ON_BIT 5
`define SEL_HI_BIT 4
`define SEL_LO_BIT 3
`define FLAG1_BIT 6
`define FLAG0_BIT 5
`define UNUSED_STATUS_BIT 3

`define ALARM_RESET 8'h00
`define PROTECT_RESET 8'h00
`define IRQCTL_RESET 8'h00
`define TRIM_RESET 8'h00

`define PULSE_OSC_CYC 8
`define PULSE_HALF_TICKS (2 * `PULSE_OSC_CYC)
`define DIV_4096_BIT 3
`define DIV_1HZ_BIT 15

`endif

// ==== rtl/rtc_pkg.sv ====
// Types shared by the alarm and clock-out block
package rtc_pkg;
  typedef enum logic [2:0] {
    PIN_IDLE = 3'b001,
    PIN_HOLD = 3'b010,
    PIN_PULSE = 3'b100
  } pin_state_t;

  typedef enum logic [1:0] {
    OUT_ALARM = 2'b00,
    OUT_32K = 2'b01,
    OUT_4096 = 2'b10,
    OUT_1HZ = 2'b11
  } clkout_sel_t;
endpackage

// ==== rtl/osc_divider.sv ====
// Divider of the oscillator half-period enable into the selectable output clocks
`timescale 1ns/10ps
`include "rtc_consts.svh"
module osc_divider (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic osc_half_tick,
  input wire rtc_pkg::clkout_sel_t sel,
  output logic clk_level
);
  logic [15:0] half_cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      half_cnt_q <= 16'h0000;
    end else if (osc_half_tick) begin
      half_cnt_q <= half_cnt_q + 16'h0001;
    end
  end

  // Each counter bit is a square wave derived from the crystal
  always_comb begin
    case (sel)
      rtc_pkg::OUT_32K: clk_level = half_cnt_q[0];
      rtc_pkg::OUT_4096: clk_level = half_cnt_q[`DIV_4096_BIT];
      rtc_pkg::OUT_1HZ: clk_level = half_cnt_q[`DIV_1HZ_BIT];
      default: clk_level = 1'b1;
    endcase
  end
endmodule

// ==== rtl/rtc_alarm_ctrl.sv ====
// Alarm compare, array write guard, interrupt or clock pin and load trim of the clock
`timescale 1ns/10ps
`include "rtc_consts.svh"
module rtc_alarm_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic osc_half_tick,
  input wire logic time_tick,
  input wire logic [7:0] time_sec,
  input wire logic [7:0] time_min,
  input wire logic [7:0] time_hour,
  input wire logic [7:0] time_date,
  input wire logic [7:0] time_month,
  input wire logic [7:0] time_dow,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic nv_restore,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic nv_save,
  output logic [7:0] nv_save_addr,
  output logic [7:0] nv_save_data,
  input wire logic ee_wr_req,
  input wire logic [8:0] ee_wr_addr,
  input wire logic [7:0] ee_wr_data,
  output logic ee_commit,
  output logic [8:0] ee_commit_addr,
  output logic [7:0] ee_commit_data,
  output logic irq_or_clock_pin,
  output logic [5:0] cap_x1_code,
  output logic [5:0] cap_x2_code
);
  logic [7:0] alarm_q [2][`ALARM_FIELDS];
  logic [7:0] now_f [`ALARM_FIELDS];
  logic [2:0] protect_sel_q;
  logic repeat_alarm_mode_q;
  logic alarm1_irq_on_q;
  logic alarm0_irq_on_q;
  logic clkout_sel_hi_q;
  logic clkout_sel_lo_q;
  logic [5:0] load_cap_trim_q;
  logic alarm0_flag_q;
  logic alarm1_flag_q;
  logic [1:0] match_prev_q;
  logic [1:0] match_now;
  logic [1:0] alarm_event;
  logic [1:0] irq_event;
  logic status_rd;
  logic alarm_out_on;
  logic clk_level;
  logic [4:0] pulse_cnt_q;
  logic save_hit;
  logic irq_any;
  logic pulse_done;
  rtc_pkg::pin_state_t pin_q;
  rtc_pkg::pin_state_t pin_d;
  rtc_pkg::clkout_sel_t sel;

  // Alarm byte offset decode: set index and field index
  function automatic logic alarm_hit(input logic [7:0] a);
    alarm_hit = (a[7:4] == 4'h0) && (a[2:0] < 3'h6);
  endfunction

  // Field takes part only when its match bit is set
  function automatic logic field_ok(input logic [7:0] al, input logic [7:0] now);
    field_ok = !al[`ALARM_MATCH_BIT] || (al[6:0] == now[6:0]);
  endfunction

  // Protected region per select code
  function automatic logic is_locked(input logic [2:0] ps, input logic [8:0] a);
    case (ps)
      3'b001: is_locked = (a >= 9'h180);
      3'b010: is_locked = (a >= 9'h100);
      3'b011: is_locked = 1'b1;
      3'b100: is_locked = (a <= 9'h03F);
      3'b101: is_locked = (a <= 9'h07F);
      3'b110: is_locked = (a <= 9'h0FF);
      3'b111: is_locked = 1'b1;
      default: is_locked = 1'b0;
    endcase
  endfunction

  // Switch code of one capacitor array; the heaviest step is wired inverted
  function automatic logic [5:0] cap_code(input logic [5:0] t);
    cap_code = {~t[5], t[4:0]};
  endfunction

  // Status byte image: the two flags, every other position reads zero
  function automatic logic [7:0] status_byte(input logic f1, input logic f0);
    status_byte = 8'h00;
    status_byte[`FLAG1_BIT] = f1;
    status_byte[`FLAG0_BIT] = f0;
    status_byte[`UNUSED_STATUS_BIT] = 1'b0;
  endfunction

  // Seconds, minutes, hours, date, month, weekday; no year field
  assign now_f[0] = time_sec;
  assign now_f[1] = time_min;
  assign now_f[2] = time_hour;
  assign now_f[3] = time_date;
  assign now_f[4] = time_month;
  assign now_f[5] = time_dow;

  assign sel = rtc_pkg::clkout_sel_t'({clkout_sel_hi_q, clkout_sel_lo_q});
  // A status read strobe stands for the eighth clock of that read
  assign status_rd = reg_rd && (reg_addr == `STATUS_OFS);

  // A set matches when at least one field is enabled and all enabled agree
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      logic any_on;
      logic all_ok;
      any_on = 1'b0;
      all_ok = 1'b1;
      for (int f = 0; f < `ALARM_FIELDS; f++) begin
        any_on = any_on | alarm_q[s][f][`ALARM_MATCH_BIT];
        all_ok = all_ok & field_ok(alarm_q[s][f], now_f[f]);
      end
      match_now[s] = any_on && all_ok;
    end
  end

  // Fire once as time advances into a match
  assign alarm_event = {2{time_tick}} & match_now & ~match_prev_q;
  // The remembered match keeps a match lasting several ticks from firing again

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      match_prev_q <= 2'b00;
    end else if (time_tick) begin
      match_prev_q <= match_now;
    end
  end

  // Alarm bytes, restored or written through the register port
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int s = 0; s < 2; s++) begin
        for (int f = 0; f < `ALARM_FIELDS; f++) begin
          alarm_q[s][f] <= `ALARM_RESET;
        end
      end
    end else if (reg_wr && alarm_hit(reg_addr)) begin
      alarm_q[reg_addr[3]][reg_addr[2:0]] <= reg_wdata;
    end
  end

  // Control settings; reset defaults until restored from storage
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      protect_sel_q <= 3'(`PROTECT_RESET);
      load_cap_trim_q <= 6'(`TRIM_RESET);
      repeat_alarm_mode_q <= 1'b0;
      alarm1_irq_on_q <= 1'b0;
      alarm0_irq_on_q <= 1'b0;
      clkout_sel_hi_q <= 1'b0;
      clkout_sel_lo_q <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `PROTECT_OFS: begin
          protect_sel_q <= reg_wdata[`PROTECT_SEL_MSB:`PROTECT_SEL_LSB];
        end
        `IRQCTL_OFS: begin
          repeat_alarm_mode_q <= reg_wdata[`REPEAT_BIT];
          alarm1_irq_on_q <= reg_wdata[`AL1_ON_BIT];
          alarm0_irq_on_q <= reg_wdata[`AL0_ON_BIT];
          clkout_sel_hi_q <= reg_wdata[`SEL_HI_BIT];
          clkout_sel_lo_q <= reg_wdata[`SEL_LO_BIT];
        end
        `TRIM_OFS: begin
          load_cap_trim_q <= reg_wdata[5:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Only mapped alarm and control bytes go to storage; the status byte is volatile
  assign save_hit = alarm_hit(reg_addr) || (reg_addr == `PROTECT_OFS)
                    || (reg_addr == `IRQCTL_OFS) || (reg_addr == `TRIM_OFS);

  // Host writes are copied out to nonvolatile storage; restores are not
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      nv_save <= 1'b0;
      nv_save_addr <= 8'h00;
      nv_save_data <= 8'h00;
    end else begin
      nv_save <= reg_wr && !nv_restore && save_hit;
      if (reg_wr && !nv_restore) begin
        nv_save_addr <= reg_addr;
        nv_save_data <= reg_wdata;
      end
    end
  end

  // Array writes pass only outside the protected region
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ee_commit <= 1'b0;
      ee_commit_addr <= 9'h000;
      ee_commit_data <= 8'h00;
    end else begin
      ee_commit <= ee_wr_req && !is_locked(protect_sel_q, ee_wr_addr);
      if (ee_wr_req) begin
        ee_commit_addr <= ee_wr_addr;
        ee_commit_data <= ee_wr_data;
      end
    end
  end

  // Flags set on a match whatever the enables; set beats the read clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      alarm0_flag_q <= 1'b0;
      alarm1_flag_q <= 1'b0;
    end else begin
      if (alarm_event[0]) begin
        alarm0_flag_q <= 1'b1;
      end else if (status_rd) begin
        alarm0_flag_q <= 1'b0;
      end
      if (alarm_event[1]) begin
        alarm1_flag_q <= 1'b1;
      end else if (status_rd) begin
        alarm1_flag_q <= 1'b0;
      end
    end
  end

  // Register read data; status bit 3 forced to zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (alarm_hit(reg_addr)) begin
        reg_rdata <= alarm_q[reg_addr[3]][reg_addr[2:0]];
      end else begin
        case (reg_addr)
          `PROTECT_OFS: reg_rdata <= {protect_sel_q, 5'h00};
          `IRQCTL_OFS: reg_rdata <= {repeat_alarm_mode_q, alarm1_irq_on_q,
                                     alarm0_irq_on_q, clkout_sel_hi_q,
                                     clkout_sel_lo_q, 3'h0};
          `TRIM_OFS: reg_rdata <= {2'h0, load_cap_trim_q};
          `STATUS_OFS: reg_rdata <= status_byte(alarm1_flag_q, alarm0_flag_q);
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Alarm signalling only with the clock output off
  assign alarm_out_on = (sel == rtc_pkg::OUT_ALARM)
                        && (alarm0_irq_on_q || alarm1_irq_on_q);
  // Either enabled set can drive the shared pin
  assign irq_event = alarm_event & {alarm1_irq_on_q, alarm0_irq_on_q};
  // Any enabled set with an event in this cycle
  assign irq_any = |irq_event;
  assign pulse_done = osc_half_tick && (pulse_cnt_q == 5'h1);

  // Pin sequencer: hold until read, or fixed-width pulses in repeat mode
  always_comb begin
    pin_d = pin_q;
    case (pin_q)
      rtc_pkg::PIN_IDLE: begin
        if (alarm_out_on && irq_any) begin
          pin_d = repeat_alarm_mode_q ? rtc_pkg::PIN_PULSE : rtc_pkg::PIN_HOLD;
        end
      end
      rtc_pkg::PIN_HOLD: begin
        // Released by reading the flags
        if (!alarm_out_on || (status_rd && !irq_any)) begin
          pin_d = rtc_pkg::PIN_IDLE;
        end
      end
      rtc_pkg::PIN_PULSE: begin
        // Ends on its own after the fixed width
        if (!alarm_out_on) begin
          pin_d = rtc_pkg::PIN_IDLE;
        end else if (irq_any) begin
          pin_d = rtc_pkg::PIN_PULSE;
        end else if (pulse_done) begin
          pin_d = rtc_pkg::PIN_IDLE;
        end
      end
      default: pin_d = rtc_pkg::PIN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pin_q <= rtc_pkg::PIN_IDLE;
    end else begin
      pin_q <= pin_d;
    end
  end

  // A new event restarts the width, so a match during a pulse lengthens it
  // Pulse width counted in oscillator half periods, restarted per event
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pulse_cnt_q <= 5'h0;
    end else if (irq_any) begin
      pulse_cnt_q <= 5'(`PULSE_HALF_TICKS);
    end else if (osc_half_tick && pulse_cnt_q != 5'h0) begin
      pulse_cnt_q <= pulse_cnt_q - 5'h1;
    end
  end

  osc_divider u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .osc_half_tick(osc_half_tick),
    .sel(sel),
    .clk_level(clk_level)
  );

  // Shared pin: clock when selected, else active-low alarm
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      // Idles high, the inactive level of the active-low alarm
      irq_or_clock_pin <= 1'b1;
    end else if (sel != rtc_pkg::OUT_ALARM) begin
      irq_or_clock_pin <= clk_level;
    end else begin
      irq_or_clock_pin <= !(pin_d != rtc_pkg::PIN_IDLE && alarm_out_on);
    end
  end

  // Both capacitor arrays take the trim code with bit 5 inverted
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cap_x1_code <= cap_code(6'(`TRIM_RESET));
      cap_x2_code <= cap_code(6'(`TRIM_RESET));
    end else begin
      cap_x1_code <= cap_code(load_cap_trim_q);
      cap_x2_code <= cap_code(load_cap_trim_q);
    end
  end
endmodule

// ==== bench/rtc_alarm_ctrl_assertions.sv ====
// Port checker of the alarm and clock-out block
`timescale 1ns/10ps
`include "rtc_consts.svh"
module rtc_alarm_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic osc_half_tick,
  input wire logic time_tick,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic ee_wr_req,
  input wire logic ee_commit,
  input wire logic irq_or_clock_pin
);
  logic [7:0] ctl_q;
  logic [4:0] low_q;
  logic st_rd;
  logic single;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  assign single = !ctl_q[7] && ctl_q[4:3] == 2'h0;
  assign st_rd = reg_rd && reg_addr == `STATUS_OFS;
  always_ff @(posedge clk_sys) begin
    if (!nrst) ctl_q <= 8'h00;
    else if (reg_wr && reg_addr == `IRQCTL_OFS) ctl_q <= reg_wdata;
  end
  // Half ticks spent low, bounds the repeat pulse
  always_ff @(posedge clk_sys) begin
    if (!nrst || irq_or_clock_pin) low_q <= 5'h00;
    else if (osc_half_tick && low_q != 5'h1F) low_q <= low_q + 5'h01;
  end
  sequence s_quiet;
    (ctl_q[6:3] == 4'h0) [*4];
  endsequence
  sequence s_fast;
    (ctl_q[4:3] == 2'h1) [*8];
  endsequence
  sequence s_held;
    !irq_or_clock_pin && single && ctl_q[6:5] != 2'h0 && !st_rd;
  endsequence
  a_commit_cause: assert property (ee_commit |-> $past(ee_wr_req))
    else $error("commit without request");
  a_status_zero: assert property (st_rd |=> {reg_rdata[7], reg_rdata[4:0]} == 6'h00)
    else $error("status unused bits not zero");
  a_pin_idle: assert property (s_quiet |-> irq_or_clock_pin)
    else $error("pin low with alarms off");
  a_single_hold: assert property (s_held |=> !irq_or_clock_pin)
    else $error("single alarm released early");
  a_read_release: assert property (st_rd && single && !time_tick |=> irq_or_clock_pin)
    else $error("pin not released by status read");
  a_pulse_width: assert property (ctl_q[7] && ctl_q[4:3] == 2'h0 |-> low_q <= 5'h12)
    else $error("repeat pulse too long");
  a_fast_clock: assert property (s_fast |-> ##[0:5] $changed(irq_or_clock_pin))
    else $error("fast clock output not toggling");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without read");
endmodule
bind rtc_alarm_ctrl rtc_alarm_ctrl_assertions chk (.clk_sys(clk_sys), .nrst(nrst),
  .osc_half_tick(osc_half_tick), .time_tick(time_tick), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ee_wr_req(ee_wr_req), .ee_commit(ee_commit), .irq_or_clock_pin(irq_or_clock_pin));

// ==== bench/host_bus.sv ====
// Host side of the register port
`timescale 1ns/10ps
`include "rtc_consts.svh"
module host_bus (
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic nv_restore,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    nv_restore = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_wdata = a == `STATUS_OFS ? d & 8'hF7 : d;
    reg_wr = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys) #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// ==== bench/tb_rtc_alarm_ctrl.sv ====
// Bench of the alarm and clock-out block
`timescale 1ns/10ps
`include "rtc_consts.svh"
module tb_rtc_alarm_ctrl;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic osc_half_tick = 1'b0;
  logic time_tick = 1'b0;
  logic ee_wr_req = 1'b0;
  logic [1:0] div_q = 2'h0;
  logic [7:0] tsec = 8'h00;
  logic [7:0] tmin = 8'h00;
  logic [8:0] ee_wr_addr = 9'h000;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, nv_save_addr, nv_save_data, rd_q;
  logic reg_wr, reg_rd, nv_restore, nv_save, ee_commit, pin;
  logic [5:0] cx1, cx2;
  logic [8:0] ee_caddr;
  logic [7:0] ee_cdata;
  int errors = 0;
  int n_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    #1;
    div_q = div_q + 2'h1;
    osc_half_tick = div_q == 2'h0;
  end
  host_bus host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .nv_restore(nv_restore), .reg_wdata(reg_wdata));
  rtc_alarm_ctrl uut (.clk_sys(clk_sys), .nrst(nrst), .osc_half_tick(osc_half_tick),
    .time_tick(time_tick), .time_sec(tsec), .time_min(tmin), .time_hour(8'h00),
    .time_date(8'h01), .time_month(8'h01), .time_dow(8'h00), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .nv_restore(nv_restore), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .nv_save(nv_save), .nv_save_addr(nv_save_addr),
    .nv_save_data(nv_save_data), .ee_wr_req(ee_wr_req), .ee_wr_addr(ee_wr_addr),
    .ee_wr_data(ee_wr_addr[7:0]), .ee_commit(ee_commit), .ee_commit_addr(ee_caddr),
    .ee_commit_data(ee_cdata), .irq_or_clock_pin(pin), .cap_x1_code(cx1),
    .cap_x2_code(cx2));
  task automatic end_sim;
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pchk(input logic v);
    chk("irq_or_clock_pin", {7'h00, v}, {7'h00, pin});
  endtask
  task automatic wait_pin(input logic v);
    for (int i = 0; i < 100 && pin !== v; i++) @(posedge clk_sys) #1;
    pchk(v);
    if (pin !== v) end_sim();
  endtask
  task automatic tick(input logic [7:0] s, input logic [7:0] m);
    @(posedge clk_sys) #1;
    tsec = s;
    tmin = m;
    time_tick = 1'b1;
    @(posedge clk_sys) #1;
    time_tick = 1'b0;
  endtask
  task automatic ee(input logic [8:0] a, input logic e);
    @(posedge clk_sys) #1;
    ee_wr_addr = a;
    ee_wr_req = 1'b1;
    @(posedge clk_sys) #1;
    ee_wr_req = 1'b0;
    chk("ee_commit", {7'h00, e}, {7'h00, ee_commit});
    if (e) begin
      chk("ee_commit_addr", a[8:1], ee_caddr[8:1]);
      chk("ee_commit_data", a[7:0], ee_cdata);
    end
  endtask
  function automatic logic locked(input logic [2:0] s, input logic [8:0] a);
    case (s)
      3'h1: return a >= 9'h180;
      3'h2: return a >= 9'h100;
      3'h4: return a <= 9'h03F;
      3'h5: return a <= 9'h07F;
      3'h6: return a <= 9'h0FF;
      default: return s[1] & s[0];
    endcase
  endfunction
  task automatic t_reset;
    pchk(1'b1);
    host.rd(`ALARM0_BASE, rd_q);
    chk("alarm0_seconds", 8'h00, rd_q);
    host.rd(`PROTECT_OFS, rd_q);
    chk("write_guard_select", 8'h00, rd_q);
    host.rd(`TRIM_OFS, rd_q);
    chk("load_cap_trim", 8'h00, rd_q);
    chk("cap_x1_code", 8'h20, {2'h0, cx1});
  endtask
  task automatic t_regs;
    logic [5:0] t;
    t = 6'h00;
    host.wr(`ALARM0_BASE, 8'hD9);
    chk("nv_save", 8'hD9, {nv_save, nv_save_data[6:0]});
    host.rd(`ALARM0_BASE, rd_q);
    chk("alarm0_seconds", 8'hD9, rd_q);
    repeat (4) begin
      host.wr(`TRIM_OFS, {2'h0, t});
      chk("nv_save_addr", `TRIM_OFS, nv_save_addr);
      chk("nv_save_data", {2'h0, t}, nv_save_data);
      @(posedge clk_sys) #1;
      chk("cap_x1_code", {2'h0, ~t[5], t[4:0]}, {2'h0, cx1});
      chk("cap_x2_code", {2'h0, ~t[5], t[4:0]}, {2'h0, cx2});
      t = t + 6'h15;
    end
  endtask
  task automatic t_guard;
    logic [8:0] adr [10] = '{9'h000, 9'h03F, 9'h040, 9'h07F, 9'h080, 9'h0FF, 9'h100,
      9'h17F, 9'h180, 9'h1FF};
    for (int s = 0; s < 8; s++) begin
      host.wr(`PROTECT_OFS, {3'(s), 5'h00});
      foreach (adr[i]) ee(adr[i], !locked(3'(s), adr[i]));
    end
    host.wr(`PROTECT_OFS, 8'h00);
  endtask
  task automatic t_single;
    host.wr(`ALARM0_BASE, 8'h85);
    host.wr(`IRQCTL_OFS, 8'h20);
    tick(8'h04, 8'h33);
    pchk(1'b1);
    tick(8'h05, 8'h17);
    pchk(1'b0);
    tick(8'h06, 8'h18);
    pchk(1'b0);
    host.rd(`STATUS_OFS, rd_q);
    chk("status_byte", 8'h20, rd_q);
    pchk(1'b1);
    host.wr(`IRQCTL_OFS, 8'h00);
    tick(8'h04, 8'h00);
    tick(8'h05, 8'h00);
    pchk(1'b1);
    host.rd(`STATUS_OFS, rd_q);
    chk("status_byte", 8'h20, rd_q);
  endtask
  task automatic t_repeat;
    host.wr(`ALARM1_BASE + 8'h01, 8'h90);
    host.wr(`IRQCTL_OFS, 8'hE0);
    repeat (2) begin
      tick(8'h04, 8'h00);
      tick(8'h05, 8'h00);
      pchk(1'b0);
      repeat (3 * `PULSE_HALF_TICKS) @(posedge clk_sys) #1;
      pchk(1'b0);
      wait_pin(1'b1);
    end
    tick(8'h30, 8'h10);
    pchk(1'b0);
    wait_pin(1'b1);
    host.wr(`IRQCTL_OFS, 8'h00);
  endtask
  task automatic t_clkout;
    logic [7:0] ctl [3] = '{8'h28, 8'h30, 8'h38};
    logic [7:0] e [3] = '{8'h40, 8'h08, 8'h00};
    logic [7:0] n;
    logic last;
    for (int k = 0; k < 3; k++) begin
      host.wr(`IRQCTL_OFS, ctl[k]);
      tick(8'h04, 8'h00);
      tick(8'h05, 8'h00);
      n = 8'h00;
      last = pin;
      for (int i = 0; i < 256; i++) begin
        @(posedge clk_sys) #1;
        if (pin !== last) n++;
        last = pin;
      end
      chk("clock edges", e[k], n);
    end
    host.wr(`IRQCTL_OFS, 8'h00);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_reset();
    t_regs();
    t_guard();
    t_single();
    t_repeat();
    t_clkout();
    end_sim();
  end
endmodule
